// File: hw/alp_core.sv
// light persistence filter and modulator residual limit configuration
`default_nettype none
module alp_core #(
    parameter int DATA_W = 16,
    parameter int BASE_START_CYCLES = 32
) (
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    input wire logic SAMPLE_VALID,
    input wire logic [DATA_W-1:0] MOD0_DATA,
    input wire logic [DATA_W-1:0] MOD1_DATA,
    input wire logic [DATA_W-1:0] LIGHT_LOW_THRESHOLD,
    input wire logic [DATA_W-1:0] LIGHT_HIGH_THRESHOLD,
    output logic LIGHT_IRQ_EVENT,
    output logic IRQ,
    output logic [7:0] START_CYCLES,
    output logic [2:0] RESIDUAL_FLOOR,
    output logic [2:0] RESIDUAL_CEILING
);
    localparam int IRQ_W = alp_pkg::IRQ_WIDTH;
    logic [7:0] filter_cfg_reg;
    logic [7:0] residual_cfg_reg;
    logic [IRQ_W-1:0] irq_status_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [7:0] miss_cnt_reg;
    logic [7:0] miss_cnt_next;
    logic [7:0] rdata_next;
    logic event_next;

    // register decode
    wire wr_filter = REG_WR && (REG_ADDR == alp_pkg::ADDR_FILTER_CFG);
    wire wr_resid = REG_WR && (REG_ADDR == alp_pkg::ADDR_RESIDUAL_CFG);
    wire wr_mask = REG_WR && (REG_ADDR == alp_pkg::ADDR_IRQ_MASK);
    wire rd_status = REG_RD && (REG_ADDR == alp_pkg::ADDR_IRQ_STATUS);

    // field extraction
    wire [3:0] light_irq_persistence = filter_cfg_reg[alp_pkg::PERS_LSB +: 4];
    wire [1:0] threshold_channel_select = filter_cfg_reg[alp_pkg::CHAN_LSB +: 2];
    wire full_start_procedure_en = residual_cfg_reg[alp_pkg::FULL_START_BIT];
    wire [1:0] residual_floor = residual_cfg_reg[alp_pkg::FLOOR_LSB +: 2];
    wire [1:0] residual_ceiling = residual_cfg_reg[alp_pkg::CEIL_LSB +: 2];

    // channel choice; codes above 01 are reserved and fall back to modulator one
    wire [DATA_W-1:0] light_sample = (threshold_channel_select == alp_pkg::CHAN_MOD0) ?
        MOD0_DATA : MOD1_DATA; // RULE1
    wire out_of_range = (light_sample < LIGHT_LOW_THRESHOLD) ||
        (light_sample > LIGHT_HIGH_THRESHOLD); // RULE2

    // required consecutive misses: linear up to 3, then five per step
    wire [7:0] pers_ext = {4'h0, light_irq_persistence};
    wire [7:0] pers_need = (light_irq_persistence <= alp_pkg::PERS_LINEAR_TOP) ? pers_ext :
        8'((pers_ext - 8'(alp_pkg::PERS_LINEAR_TOP)) * alp_pkg::PERS_STEP); // RULE4 RULE5

    // saturating miss counter, cleared by any in-range sample
    wire [7:0] miss_inc = (miss_cnt_reg == 8'hff) ? miss_cnt_reg : miss_cnt_reg + 8'h01;
    always_comb begin
        miss_cnt_next = miss_cnt_reg;
        event_next = 1'b0;
        if (SAMPLE_VALID) begin
            if (!out_of_range) begin
                miss_cnt_next = 8'h00; // RULE3
            end else begin
                miss_cnt_next = miss_inc; // RULE2
            end
            if (light_irq_persistence == 4'h0) begin
                event_next = 1'b1; // RULE4
            end else begin
                event_next = out_of_range && (miss_inc == pers_need); // RULE2
            end
        end
    end

    // status read data; status read clears, but a same-cycle event wins
    wire [IRQ_W-1:0] status_set = event_next ? {IRQ_W{1'b1}} : {IRQ_W{1'b0}};
    wire [IRQ_W-1:0] status_next = (rd_status ? {IRQ_W{1'b0}} : irq_status_reg) | status_set;
    wire [7:0] state_word = miss_cnt_reg;
    always_comb begin
        rdata_next = 8'h00;
        if (REG_RD) begin
            case (REG_ADDR)
                alp_pkg::ADDR_FILTER_CFG: rdata_next = filter_cfg_reg;
                alp_pkg::ADDR_RESIDUAL_CFG: rdata_next = residual_cfg_reg;
                alp_pkg::ADDR_IRQ_STATUS: rdata_next = 8'(irq_status_reg);
                alp_pkg::ADDR_IRQ_MASK: rdata_next = 8'(irq_mask_reg);
                alp_pkg::ADDR_LIGHT_STATE: rdata_next = state_word;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // shortened sample length and residual limits for the modulator
    wire [7:0] base_start = 8'(BASE_START_CYCLES);
    wire [7:0] start_next = full_start_procedure_en ?
        base_start - 8'(alp_pkg::START_SHORTEN_CYCLES) : base_start; // RULE6
    wire [2:0] floor_next = {1'b0, residual_floor}; // RULE7
    wire [2:0] ceil_next = {1'b0, residual_ceiling} + alp_pkg::RESIDUAL_CEIL_OFFSET; // RULE8

    // configuration registers; reserved bits stay zero
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            filter_cfg_reg <= alp_pkg::RST_FILTER_CFG;
            residual_cfg_reg <= alp_pkg::RST_RESIDUAL_CFG;
            irq_mask_reg <= '0;
        end else begin
            if (wr_filter) begin
                filter_cfg_reg <= REG_WDATA & alp_pkg::FILTER_CFG_MASK;
            end
            if (wr_resid) begin
                residual_cfg_reg <= REG_WDATA & alp_pkg::RESIDUAL_CFG_MASK;
            end
            if (wr_mask) begin
                irq_mask_reg <= REG_WDATA[IRQ_W-1:0];
            end
        end
    end

    // filter state, status and outputs
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            miss_cnt_reg <= 8'h00;
            irq_status_reg <= '0;
            REG_RDATA <= 8'h00;
            LIGHT_IRQ_EVENT <= 1'b0;
            IRQ <= 1'b0;
            START_CYCLES <= 8'h00;
            RESIDUAL_FLOOR <= 3'h0;
            RESIDUAL_CEILING <= 3'h4;
        end else begin
            miss_cnt_reg <= miss_cnt_next;
            irq_status_reg <= status_next;
            REG_RDATA <= rdata_next;
            LIGHT_IRQ_EVENT <= event_next;
            IRQ <= |(status_next & irq_mask_reg);
            START_CYCLES <= start_next;
            RESIDUAL_FLOOR <= floor_next;
            RESIDUAL_CEILING <= ceil_next;
        end
    end

    // every in-range sample leaves the counter at zero
    a_miss_clear: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE3
        SAMPLE_VALID && !out_of_range |=> miss_cnt_reg == 8'h00)
        else $error("miss counter not cleared by in-range sample");

    // code 0 fires on every sample
    a_pers_zero: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE4
        SAMPLE_VALID && light_irq_persistence == 4'h0 |=> LIGHT_IRQ_EVENT)
        else $error("persistence zero missed a sample");

    // no event from an in-range sample unless code 0
    a_no_event_in: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE2
        SAMPLE_VALID && !out_of_range && light_irq_persistence != 4'h0 |=> !LIGHT_IRQ_EVENT)
        else $error("event from in-range sample");

    // code 0xf needs sixty misses
    a_pers_sixty: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE5
        light_irq_persistence == 4'hf |-> pers_need == 8'h3c)
        else $error("code f does not need sixty");

    // code 4 needs five misses
    a_pers_five: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE5
        light_irq_persistence == 4'h4 |-> pers_need == 8'h05)
        else $error("code 4 does not need five");

    // event fires exactly when the count reaches the need
    a_event_count: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE2
        LIGHT_IRQ_EVENT && light_irq_persistence != 4'h0 && $stable(filter_cfg_reg)
        |-> miss_cnt_reg == pers_need)
        else $error("event at wrong miss count");

    // channel select steers the compared sample
    a_chan_sel: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE1
        threshold_channel_select == 2'h1 |-> light_sample == MOD1_DATA)
        else $error("channel one not selected");

    // shortened start is nine cycles less two cycles after the bit is set
    a_start_short: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE6
        full_start_procedure_en ##1 full_start_procedure_en
        |-> START_CYCLES == 8'(BASE_START_CYCLES) - 8'(alp_pkg::START_SHORTEN_CYCLES))
        else $error("start not shortened by nine");

    // ceiling output is field plus one
    a_ceil_limit: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE8
        $stable(residual_ceiling) |=> RESIDUAL_CEILING == {1'b0, $past(residual_ceiling)} + 3'h1)
        else $error("ceiling not code plus one");

    // floor output follows field
    a_floor_limit: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE7
        $stable(residual_floor) |=> RESIDUAL_FLOOR == {1'b0, $past(residual_floor)})
        else $error("floor not code value");

    // channel zero steers modulator zero
    a_chan_zero: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE1
        threshold_channel_select == alp_pkg::CHAN_MOD0 |-> light_sample == MOD0_DATA)
        else $error("channel zero not selected");

    // each miss below saturation adds one
    a_miss_count: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE2
        SAMPLE_VALID && out_of_range && miss_cnt_reg != 8'hff |=> miss_cnt_reg == $past(miss_cnt_reg) + 8'h01)
        else $error("miss counter did not advance");

    // counter only moves on a sample
    a_miss_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE2
        !SAMPLE_VALID |=> $stable(miss_cnt_reg))
        else $error("miss counter moved without sample");

    // counter saturates rather than wrapping back to a firing count
    a_miss_sat: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE2
        SAMPLE_VALID && out_of_range && miss_cnt_reg == 8'hff |=> miss_cnt_reg == 8'hff)
        else $error("miss counter wrapped");

    // event pulse always leaves the sticky status set
    a_event_status: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE2
        LIGHT_IRQ_EVENT |-> irq_status_reg[alp_pkg::IRQ_LIGHT])
        else $error("event without status");

    // no event without a sample
    a_no_event_idle: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE2
        !SAMPLE_VALID |=> !LIGHT_IRQ_EVENT)
        else $error("event without sample");

    // code 1 needs one miss
    a_pers_one: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE4
        light_irq_persistence == 4'h1 |-> pers_need == 8'h01)
        else $error("code 1 does not need one");

    // code 2 needs two misses
    a_pers_two: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE4
        light_irq_persistence == 4'h2 |-> pers_need == 8'h02)
        else $error("code 2 does not need two");

    // code 3 needs three misses
    a_pers_three: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE4
        light_irq_persistence == 4'h3 |-> pers_need == 8'h03)
        else $error("code 3 does not need three");

    // code 1 fires on the first miss of a run
    a_pers_one_fire: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE4
        SAMPLE_VALID && light_irq_persistence == 4'h1 && out_of_range && miss_cnt_reg == 8'h00
        |=> LIGHT_IRQ_EVENT)
        else $error("code 1 missed first miss");

    // code 5 needs ten misses
    a_pers_ten: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE5
        light_irq_persistence == 4'h5 |-> pers_need == 8'h0a)
        else $error("code 5 does not need ten");

    // code 6 needs fifteen misses
    a_pers_fifteen: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE5
        light_irq_persistence == 4'h6 |-> pers_need == 8'h0f)
        else $error("code 6 does not need fifteen");

    // code 7 needs twenty misses
    a_pers_twenty: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE5
        light_irq_persistence == 4'h7 |-> pers_need == 8'h14)
        else $error("code 7 does not need twenty");

    // code 8 needs twenty-five misses
    a_pers_code8: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE5
        light_irq_persistence == 4'h8 |-> pers_need == 8'h19)
        else $error("code 8 does not need twenty-five");

    // code 9 needs thirty misses
    a_pers_code9: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE5
        light_irq_persistence == 4'h9 |-> pers_need == 8'h1e)
        else $error("code 9 does not need thirty");

    // code a needs thirty-five misses
    a_pers_code_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE5
        light_irq_persistence == 4'ha |-> pers_need == 8'h23)
        else $error("code a does not need thirty-five");

    // code b needs forty misses
    a_pers_code_b: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE5
        light_irq_persistence == 4'hb |-> pers_need == 8'h28)
        else $error("code b does not need forty");

    // code c needs forty-five misses
    a_pers_code_c: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE5
        light_irq_persistence == 4'hc |-> pers_need == 8'h2d)
        else $error("code c does not need forty-five");

    // code d needs fifty misses
    a_pers_code_d: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE5
        light_irq_persistence == 4'hd |-> pers_need == 8'h32)
        else $error("code d does not need fifty");

    // code e needs fifty-five misses
    a_pers_code_e: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE5
        light_irq_persistence == 4'he |-> pers_need == 8'h37)
        else $error("code e does not need fifty-five");

    // normal start keeps the full length; reset edge excluded
    a_start_normal: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE6
        RST_B && !full_start_procedure_en ##1 !full_start_procedure_en
        |-> START_CYCLES == 8'(BASE_START_CYCLES))
        else $error("start shortened while bit clear");

    // ceiling output stays within one to four bits
    a_ceil_range: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE8
        RESIDUAL_CEILING >= 3'h1 && RESIDUAL_CEILING <= 3'h4)
        else $error("ceiling out of range");

    // floor output stays within zero to three bits
    a_floor_range: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE7
        RESIDUAL_FLOOR <= 3'h3)
        else $error("floor out of range");

    // level follows status and the mask of the cycle before
    a_irq_level: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        IRQ == |(irq_status_reg & $past(irq_mask_reg)))
        else $error("irq level wrong");

    // fully masked status never reaches the pin
    a_irq_masked: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        irq_mask_reg == '0 ##1 irq_mask_reg == '0 |-> !IRQ)
        else $error("masked irq asserted");

    // status read clears unless an event lands at once
    a_status_clear: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE2
        rd_status && !event_next |=> irq_status_reg == '0)
        else $error("status not cleared by read");

    // status holds until read
    a_status_sticky: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE2
        irq_status_reg[alp_pkg::IRQ_LIGHT] && !rd_status |=> irq_status_reg[alp_pkg::IRQ_LIGHT])
        else $error("status dropped without read");

    // read data is zero outside the answer cycle
    a_rdata_idle: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        !REG_RD |=> REG_RDATA == 8'h00)
        else $error("read data outside answer cycle");

    // reserved filter bits never hold a one
    a_cfg_reserved: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE1
        (filter_cfg_reg & ~alp_pkg::FILTER_CFG_MASK) == 8'h00)
        else $error("reserved filter bit set");

    // reserved residual bits never hold a one
    a_resid_reserved: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE7
        (residual_cfg_reg & ~alp_pkg::RESIDUAL_CFG_MASK) == 8'h00)
        else $error("reserved residual bit set");
endmodule
`default_nettype wire

// File: shared/alp_pkg.sv
// constants for the light persistence and residual config block
// Contract
// (RULE1) The threshold channel select code picks which modulator sample is compared, 00 for zero and 01 for one.
// (RULE2) Consecutive out-of-range light samples are counted and the light interrupt fires only once the persistence setting is met.
// (RULE3) Any light sample inside the threshold range clears the consecutive counter to zero.
// (RULE4) Persistence 0x0 fires on every cycle, 0x1 on any single miss, 0x2 and 0x3 after two or three misses.
// (RULE5) Persistence from 0x4 up needs five misses per step above 0x3, so 0x4 needs five and 0xF needs sixty.
// (RULE6) With the full start procedure bit set each sample is shortened by nine modulator clock cycles.
// (RULE7) The residual floor field forces at least its code value of residual bits, and 00b switches it off.
// (RULE8) The residual ceiling field caps residual bits at its code plus one, with reset code 0x3 giving four.
// (RULE9) Software that moves a residual limit off its default must enable residual calibration.
`default_nettype none
package alp_pkg;
    localparam logic [7:0] ADDR_FILTER_CFG = 8'ha6;
    localparam logic [7:0] ADDR_RESIDUAL_CFG = 8'ha7;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'hb8;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'hb9;
    localparam logic [7:0] ADDR_LIGHT_STATE = 8'hbb;
    localparam logic [7:0] RST_FILTER_CFG = 8'h00;
    localparam logic [7:0] RST_RESIDUAL_CFG = 8'h03;
    localparam logic [7:0] FILTER_CFG_MASK = 8'h3f;
    localparam logic [7:0] RESIDUAL_CFG_MASK = 8'h2f;
    localparam int PERS_LSB = 0;
    localparam int CHAN_LSB = 4;
    localparam int CEIL_LSB = 0;
    localparam int FLOOR_LSB = 2;
    localparam int FULL_START_BIT = 5;
    localparam logic [1:0] CHAN_MOD0 = 2'h0;
    localparam logic [1:0] CHAN_MOD1 = 2'h1;
    localparam logic [3:0] PERS_LINEAR_TOP = 4'h3;
    localparam logic [7:0] PERS_STEP = 8'h05;
    localparam logic [3:0] START_SHORTEN_CYCLES = 4'h9;
    localparam logic [2:0] RESIDUAL_CEIL_OFFSET = 3'h1;
    localparam int IRQ_LIGHT = 0;
    localparam int IRQ_WIDTH = 1;
endpackage
`default_nettype wire

// File: tb/test_alp_core.sv
// self-checking bench for the light persistence and residual config block
`default_nettype none
module test_alp_core;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst_b, wr_s, rd_s, vld, ev, irq, exp_ev, exp_irq, chk_on, irq_on;
    logic [7:0] addr, wdata, rdata, start_c;
    logic [2:0] floor_v, ceil_v;
    logic [15:0] m0, m1;
    int err_total, checks_done, i, k, n;
    // rows: write value, readback, floor, ceiling, start cycles
    logic [39:0] rows [4] = '{40'h00_00_00_01_20, 40'h25_25_01_02_17,
        40'h0e_0e_03_03_20, 40'hff_2f_03_04_17};
    logic [3:0] codes [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hf};

    alp_core DUT (.CORE_CLK(clk), .RST_B(rst_b), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata), .SAMPLE_VALID(vld),
        .MOD0_DATA(m0), .MOD1_DATA(m1), .LIGHT_LOW_THRESHOLD(16'd100),
        .LIGHT_HIGH_THRESHOLD(16'd200), .LIGHT_IRQ_EVENT(ev), .IRQ(irq),
        .START_CYCLES(start_c), .RESIDUAL_FLOOR(floor_v), .RESIDUAL_CEILING(ceil_v));

    task automatic complete_run;
        if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic step;
        @(posedge clk);
        exp_ev = 1'b0;
    endtask
    // one-cycle strobe, then an idle edge so strobes never collide
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        vld <= 1'b0;
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        step;
        wr_s <= 1'b0;
        step;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        vld <= 1'b0;
        addr <= a;
        rd_s <= 1'b1;
        step;
        rd_s <= 1'b0;
        #1 cmp("rdata", e, rdata);
        step;
    endtask
    // samples go back to back; event is judged in the following cycle
    task automatic smp(input logic [15:0] a, input logic [15:0] b, input logic e);
        m0 <= a;
        m1 <= b;
        vld <= 1'b1;
        @(posedge clk);
        exp_ev = e;
    endtask
    task automatic outs(input logic [7:0] f, input logic [7:0] c, input logic [7:0] s);
        #1 cmp("floor", f, {5'h0, floor_v});
        cmp("ceiling", c, {5'h0, ceil_v});
        cmp("start", s, start_c);
        step;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // hang guard: the whole run is far shorter
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        complete_run;
    end
    // pulse watched every cycle, level only while irq_on is set, away from the launching edge
    always @(negedge clk) begin
        if (chk_on) cmp("event", {7'h0, exp_ev}, {7'h0, ev});
        if (irq_on) cmp("irq", {7'h0, exp_irq}, {7'h0, irq});
    end

    initial begin
        {rst_b, wr_s, rd_s, vld, exp_ev, exp_irq, chk_on, irq_on} = 8'h00;
        {addr, wdata, m0, m1, err_total, checks_done} = '0;
        repeat (8) @(posedge clk);
        outs(8'h00, 8'h04, 8'h00);
        rst_b <= 1'b1;
        {chk_on, irq_on} = 2'b11;
        step;
        outs(8'h00, 8'h04, 8'h20);
        rd(alp_pkg::ADDR_FILTER_CFG, 8'h00);
        rd(alp_pkg::ADDR_RESIDUAL_CFG, 8'h03);
        // limits moved off default here; calibration enable is outside this block
        for (i = 0; i < 4; i++) begin
            wr(alp_pkg::ADDR_RESIDUAL_CFG, rows[i][39:32]);
            step;
            outs(rows[i][23:16], rows[i][15:8], rows[i][7:0]);
            rd(alp_pkg::ADDR_RESIDUAL_CFG, rows[i][31:24]);
        end
        // each code: near miss run, clear by boundary sample, full run, no refire
        for (i = 0; i < 6; i++) begin
            wr(alp_pkg::ADDR_FILTER_CFG, {4'h0, codes[i]});
            step;
            n = (codes[i] <= 4'h3) ? int'(codes[i]) : (int'(codes[i]) - 3) * 5;
            for (k = 1; k < n; k++) smp(16'd300, 16'd300, 1'b0);
            smp(16'd200, 16'd200, 1'b0);
            for (k = 1; k < n; k++) smp(16'd50, 16'd50, 1'b0);
            smp(16'd50, 16'd50, 1'b1);
            smp(16'd300, 16'd300, 1'b0);
            smp(16'd150, 16'd150, 1'b0);
        end
        wr(alp_pkg::ADDR_FILTER_CFG, 8'h00);
        step;
        smp(16'd150, 16'd150, 1'b1);
        smp(16'd150, 16'd150, 1'b1);
        wr(alp_pkg::ADDR_FILTER_CFG, 8'h12);
        step;
        smp(16'd150, 16'd300, 1'b0);
        smp(16'd150, 16'd300, 1'b1);
        rd(alp_pkg::ADDR_LIGHT_STATE, 8'h02);
        wr(alp_pkg::ADDR_FILTER_CFG, 8'h02);
        step;
        smp(16'd150, 16'd300, 1'b0);
        smp(16'd150, 16'd300, 1'b0);
        wr(alp_pkg::ADDR_FILTER_CFG, 8'hff);
        rd(alp_pkg::ADDR_FILTER_CFG, 8'h3f);
        rd(8'h10, 8'h00);
        // status was set while masked: unmask, then read clears it
        irq_on = 1'b0;
        wr(alp_pkg::ADDR_IRQ_MASK, 8'h01);
        step;
        {exp_irq, irq_on} = 2'b11;
        step;
        irq_on = 1'b0;
        rd(alp_pkg::ADDR_IRQ_STATUS, 8'h01);
        rd(alp_pkg::ADDR_IRQ_STATUS, 8'h00);
        {exp_irq, irq_on} = 2'b01;
        step;
        complete_run;
    end
endmodule
`default_nettype wire
